// ===== rtl/ptm_top.sv
// Phase threshold event monitor: limits, mismatch, status and interrupt
//
// Behaviour
// - Voltage magnitude above limit sets high-volt flag and phase bit.
// - Phase current magnitude above limit sets high-amp flag and phase bit.
// - Masked high-volt flag drives the interrupt line low when it sets.
// - Masked high-amp flag drives the interrupt line low when it sets.
// - Writing one to high-volt flag clears it and its phase bits.
// - Writing one to high-amp flag clears it and its phase bits.
// - Limits are 24-bit unsigned; full-scale limit never detects.
// - A zero limit makes detection fire continuously.
// - Limits read as 32-bit words with upper eight bits zero.
// - Phase current total is the 28-bit signed sum of three samples.
// - Total updates each sample; ready flag marks each new total.
// - Mismatch flag sets when magnitude difference exceeds threshold.
// - Masked mismatch flag drives interrupt low; write one clears it.
// - Threshold resets to zero; zero or negative fires continuously.
// - Threshold is 24-bit signed on the current sample scale.
// - Total reads as 32 bits with four upper bits zero.
// - Threshold reads sign-extended to 28 bits, four upper bits zero.
// - Neutral select set routes total rms into neutral rms result.
`timescale 1ns/100ps
module ptm_top #(
  parameter int unsigned SAMPLE_CYCLES = ptm_pkg::SAMPLE_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [23:0] volt_a_sample_i,
  input  wire logic [23:0] volt_b_sample_i,
  input  wire logic [23:0] volt_c_sample_i,
  input  wire logic [23:0] phase_a_current_sample_i,
  input  wire logic [23:0] phase_b_current_sample_i,
  input  wire logic [23:0] phase_c_current_sample_i,
  input  wire logic [23:0] neutral_current_sample_i,
  input  wire logic [23:0] total_rms_i,
  input  wire logic [23:0] neutral_meas_rms_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             event_interrupt_line_n_o,
  output logic [23:0]      neutral_rms_result_o
);

  // ==========================================================
  // Helpers
  function automatic logic [27:0] sext28(input logic [23:0] s);
    sext28 = {{4{s[23]}}, s};
  endfunction

  function automatic logic [27:0] mag28(input logic [27:0] s);
    mag28 = s[27] ? 28'(~s + 28'h0000001) : s;
  endfunction

  function automatic logic hit_addr(input logic [7:0] a,
                                    input logic [7:0] ofs);
    hit_addr = (a == ofs);
  endfunction

  // ==========================================================
  // Registers
  logic [23:0] voltage_limit_q;
  logic [23:0] current_limit_q;
  logic [23:0] total_mismatch_threshold_q;
  logic [27:0] phase_current_total_q;
  logic        high_volt_flag_q;
  logic        high_amp_flag_q;
  logic        neutral_mismatch_flag_q;
  logic [2:0]  volt_event_phase_bits_q;
  logic [2:0]  amp_event_phase_bits_q;
  logic        mask_volt_q;
  logic        mask_amp_q;
  logic        mask_mismatch_q;
  logic        sample_ready_flag_q;
  logic        neutral_input_select_q;
  logic        mismatch_hit_q;
  logic        high_volt_flag_d;
  logic        high_amp_flag_d;
  logic        neutral_mismatch_flag_d;
  logic [2:0]  volt_event_phase_bits_d;
  logic [2:0]  amp_event_phase_bits_d;
  logic        mask_volt_d;
  logic        mask_amp_d;
  logic        mask_mismatch_d;

  logic        tick;
  logic        wr_status;
  logic        clr_volt;
  logic        clr_amp;
  logic        clr_mismatch;
  logic        clr_ready;
  logic        total_sel;
  logic [27:0] sum_now;
  logic [27:0] diff_now;
  logic        thr_nonpos;

  ptm_det_if volt_det ();
  ptm_det_if amp_det ();

  // ==========================================================
  // Sample rate and capture
  ptm_rate_div #(
    .CYCLES (SAMPLE_CYCLES)
  ) u_rate (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_o  (tick)
  );

  // Every phase of one sample is captured on the same tick
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      volt_det.sample <= '0;
      amp_det.sample  <= '0;
      volt_det.strobe <= 1'b0;
      amp_det.strobe  <= 1'b0;
    end
    else
    begin
      volt_det.strobe <= tick;
      amp_det.strobe  <= tick;
      if (tick)
      begin
        volt_det.sample <= {volt_c_sample_i, volt_b_sample_i,
                            volt_a_sample_i};
        amp_det.sample  <= {phase_c_current_sample_i,
                            phase_b_current_sample_i,
                            phase_a_current_sample_i};
      end
    end
  end

  assign volt_det.limit = voltage_limit_q;
  assign amp_det.limit  = current_limit_q;

  ptm_phase_detect u_volt_det (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .det     (volt_det)
  );

  ptm_phase_detect u_amp_det (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .det     (amp_det)
  );

  // ==========================================================
  // Phase current total and neutral mismatch
  logic [23:0] neutral_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      neutral_q <= 24'h000000;
    else if (tick)
      neutral_q <= neutral_current_sample_i;
  end

  always_comb
  begin
    sum_now = 28'(sext28(amp_det.sample[0]) + sext28(amp_det.sample[1])
                  + sext28(amp_det.sample[2]));
    if (mag28(sum_now) >= mag28(sext28(neutral_q)))
      diff_now = 28'(mag28(sum_now) - mag28(sext28(neutral_q)));
    else
      diff_now = 28'(mag28(sext28(neutral_q)) - mag28(sum_now));
    thr_nonpos = total_mismatch_threshold_q[23] ||
                 (total_mismatch_threshold_q == 24'h000000);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      phase_current_total_q <= 28'h0000000;
      mismatch_hit_q        <= 1'b0;
    end
    else if (amp_det.strobe)
    begin
      phase_current_total_q <= sum_now;
      // Threshold compared on the sample scale, strictly greater
      mismatch_hit_q <= thr_nonpos ||
        (diff_now > sext28(total_mismatch_threshold_q));
    end
  end

  // ==========================================================
  // Register writes
  always_comb
  begin
    wr_status    = reg_wr_i && hit_addr(reg_addr_i,
                                        ptm_pkg::EVENT_STATUS_OFS);
    clr_volt     = wr_status && reg_wdata_i[ptm_pkg::HIGH_VOLT_BIT];
    clr_amp      = wr_status && reg_wdata_i[ptm_pkg::HIGH_AMP_BIT];
    clr_mismatch = wr_status && reg_wdata_i[ptm_pkg::MISMATCH_BIT];
    clr_ready    = reg_wr_i &&
                   hit_addr(reg_addr_i, ptm_pkg::DSP_STATUS_OFS) &&
                   reg_wdata_i[ptm_pkg::READY_BIT];
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      voltage_limit_q            <= ptm_pkg::LIMIT_RST;
      current_limit_q            <= ptm_pkg::LIMIT_RST;
      total_mismatch_threshold_q <= ptm_pkg::MISMATCH_THR_RST;
      neutral_input_select_q     <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      if (hit_addr(reg_addr_i, ptm_pkg::VOLT_LIMIT_OFS))
        voltage_limit_q <= reg_wdata_i[23:0];
      if (hit_addr(reg_addr_i, ptm_pkg::AMP_LIMIT_OFS))
        current_limit_q <= reg_wdata_i[23:0];
      if (hit_addr(reg_addr_i, ptm_pkg::MISMATCH_THR_OFS))
        total_mismatch_threshold_q <= reg_wdata_i[23:0];
      if (hit_addr(reg_addr_i, ptm_pkg::CONFIG_OFS))
        neutral_input_select_q <= reg_wdata_i[ptm_pkg::NEUTRAL_SEL_BIT];
    end
  end

  // ==========================================================
  // Event flags: a new event wins over a clear in the same cycle
  always_comb
  begin
    high_volt_flag_d        = high_volt_flag_q;
    volt_event_phase_bits_d = volt_event_phase_bits_q;
    if (clr_volt)
    begin
      high_volt_flag_d        = 1'b0;
      volt_event_phase_bits_d = 3'h0;
    end
    if (volt_det.hit_valid && (volt_det.hit != 3'h0))
    begin
      high_volt_flag_d        = 1'b1;
      volt_event_phase_bits_d = volt_event_phase_bits_d |
                                volt_det.hit;
    end

    high_amp_flag_d        = high_amp_flag_q;
    amp_event_phase_bits_d = amp_event_phase_bits_q;
    if (clr_amp)
    begin
      high_amp_flag_d        = 1'b0;
      amp_event_phase_bits_d = 3'h0;
    end
    if (amp_det.hit_valid && (amp_det.hit != 3'h0))
    begin
      high_amp_flag_d        = 1'b1;
      amp_event_phase_bits_d = amp_event_phase_bits_d |
                               amp_det.hit;
    end

    neutral_mismatch_flag_d = neutral_mismatch_flag_q;
    if (clr_mismatch)
      neutral_mismatch_flag_d = 1'b0;
    if (amp_det.hit_valid && mismatch_hit_q)
      neutral_mismatch_flag_d = 1'b1;

    mask_volt_d     = mask_volt_q;
    mask_amp_d      = mask_amp_q;
    mask_mismatch_d = mask_mismatch_q;
    if (reg_wr_i && hit_addr(reg_addr_i, ptm_pkg::EVENT_MASK_OFS))
    begin
      mask_volt_d     = reg_wdata_i[ptm_pkg::HIGH_VOLT_BIT];
      mask_amp_d      = reg_wdata_i[ptm_pkg::HIGH_AMP_BIT];
      mask_mismatch_d = reg_wdata_i[ptm_pkg::MISMATCH_BIT];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      high_volt_flag_q        <= 1'b0;
      high_amp_flag_q         <= 1'b0;
      neutral_mismatch_flag_q <= 1'b0;
      volt_event_phase_bits_q <= 3'h0;
      amp_event_phase_bits_q  <= 3'h0;
      mask_volt_q             <= 1'b0;
      mask_amp_q              <= 1'b0;
      mask_mismatch_q         <= 1'b0;
    end
    else
    begin
      high_volt_flag_q        <= high_volt_flag_d;
      high_amp_flag_q         <= high_amp_flag_d;
      neutral_mismatch_flag_q <= neutral_mismatch_flag_d;
      volt_event_phase_bits_q <= volt_event_phase_bits_d;
      amp_event_phase_bits_q  <= amp_event_phase_bits_d;
      mask_volt_q             <= mask_volt_d;
      mask_amp_q              <= mask_amp_d;
      mask_mismatch_q         <= mask_mismatch_d;
    end
  end

  // Line falls on the same edge the flag sets, rises when it clears
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      event_interrupt_line_n_o <= 1'b1;
    else
      event_interrupt_line_n_o <=
        !((high_volt_flag_d && mask_volt_d) ||
          (high_amp_flag_d && mask_amp_d) ||
          (neutral_mismatch_flag_d && mask_mismatch_d));
  end

  // ==========================================================
  // Ready flag and neutral rms result
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      sample_ready_flag_q <= 1'b0;
    else if (amp_det.hit_valid)
      sample_ready_flag_q <= 1'b1;
    else if (clr_ready)
      sample_ready_flag_q <= 1'b0;
  end

  assign total_sel = neutral_input_select_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      neutral_rms_result_o <= 24'h000000;
    else if (tick)
      neutral_rms_result_o <= total_sel ? total_rms_i
                                        : neutral_meas_rms_i;
  end

  // ==========================================================
  // Register reads: one cycle after the read strobe
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o  <= 32'h00000000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= 32'h00000000;
        unique case (reg_addr_i)
          ptm_pkg::VOLT_LIMIT_OFS:
            reg_rdata_o <= {8'h00, voltage_limit_q};
          ptm_pkg::AMP_LIMIT_OFS:
            reg_rdata_o <= {8'h00, current_limit_q};
          ptm_pkg::TOTAL_OFS:
            reg_rdata_o <= {4'h0, phase_current_total_q};
          ptm_pkg::MISMATCH_THR_OFS:
            reg_rdata_o <= {4'h0,
              sext28(total_mismatch_threshold_q)};
          ptm_pkg::EVENT_STATUS_OFS:
          begin
            reg_rdata_o[ptm_pkg::HIGH_VOLT_BIT] <= high_volt_flag_q;
            reg_rdata_o[ptm_pkg::HIGH_AMP_BIT]  <= high_amp_flag_q;
            reg_rdata_o[ptm_pkg::MISMATCH_BIT]  <= neutral_mismatch_flag_q;
          end
          ptm_pkg::PHASE_STATUS_OFS:
          begin
            reg_rdata_o[ptm_pkg::VOLT_PHASE_LSB +: 3] <=
              volt_event_phase_bits_q;
            reg_rdata_o[ptm_pkg::AMP_PHASE_LSB +: 3] <=
              amp_event_phase_bits_q;
          end
          ptm_pkg::EVENT_MASK_OFS:
          begin
            reg_rdata_o[ptm_pkg::HIGH_VOLT_BIT] <= mask_volt_q;
            reg_rdata_o[ptm_pkg::HIGH_AMP_BIT]  <= mask_amp_q;
            reg_rdata_o[ptm_pkg::MISMATCH_BIT]  <= mask_mismatch_q;
          end
          ptm_pkg::DSP_STATUS_OFS:
            reg_rdata_o[ptm_pkg::READY_BIT] <= sample_ready_flag_q;
          ptm_pkg::CONFIG_OFS:
            reg_rdata_o[ptm_pkg::NEUTRAL_SEL_BIT] <= neutral_input_select_q;
          ptm_pkg::NEUTRAL_RMS_OFS:
            reg_rdata_o <= {8'h00, neutral_rms_result_o};
          default:
            reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ===== common/ptm_pkg.sv
// Constants shared by the phase threshold event monitor
package ptm_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned TOTAL_W  = 28;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PHASES   = 3;

  // ==========================================================
  // Reset values and scale
  localparam logic [23:0] FULL_SCALE       = 24'h5A7540;
  localparam logic [23:0] LIMIT_RST        = 24'h5A7540;
  localparam logic [23:0] MISMATCH_THR_RST = 24'h000000;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] VOLT_LIMIT_OFS   = 8'h00;
  localparam logic [7:0] AMP_LIMIT_OFS    = 8'h04;
  localparam logic [7:0] TOTAL_OFS        = 8'h08;
  localparam logic [7:0] MISMATCH_THR_OFS = 8'h0C;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h10;
  localparam logic [7:0] PHASE_STATUS_OFS = 8'h14;
  localparam logic [7:0] EVENT_MASK_OFS   = 8'h18;
  localparam logic [7:0] DSP_STATUS_OFS   = 8'h1C;
  localparam logic [7:0] CONFIG_OFS       = 8'h20;
  localparam logic [7:0] NEUTRAL_RMS_OFS  = 8'h24;

  // ==========================================================
  // Field positions
  localparam int unsigned HIGH_AMP_BIT    = 17;
  localparam int unsigned HIGH_VOLT_BIT   = 18;
  localparam int unsigned MISMATCH_BIT    = 20;
  localparam int unsigned VOLT_PHASE_LSB  = 9;
  localparam int unsigned AMP_PHASE_LSB   = 3;
  localparam int unsigned READY_BIT       = 17;
  localparam int unsigned NEUTRAL_SEL_BIT = 0;

  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_PERIOD_NS  = 25;
  localparam int unsigned SAMPLE_PERIOD_NS = 125000;
  localparam int unsigned SAMPLE_CYCLES    =
    SAMPLE_PERIOD_NS / CLOCK_PERIOD_NS;

endpackage

// ===== common/ptm_det_if.sv
// Carrier between the sample path and a threshold detector
`timescale 1ns/100ps
interface ptm_det_if;
  logic [2:0][23:0] sample;
  logic [23:0]      limit;
  logic             strobe;
  logic [2:0]       hit;
  logic             hit_valid;

  modport ctrl (output sample, limit, strobe, input hit, hit_valid);
  modport det  (input sample, limit, strobe, output hit, hit_valid);
endinterface

// ===== rtl/ptm_rate_div.sv
// Divider giving a one-cycle pulse at the DSP sample rate
`timescale 1ns/100ps
module ptm_rate_div #(
  parameter int unsigned CYCLES = ptm_pkg::SAMPLE_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [15:0] count_q;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      count_q <= 16'h0000;
      tick_o  <= 1'b0;
    end
    else if (count_q == 16'(CYCLES - 1))
    begin
      count_q <= 16'h0000;
      tick_o  <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 16'h0001;
      tick_o  <= 1'b0;
    end
  end
endmodule

// ===== rtl/ptm_phase_detect.sv
// Per-phase absolute value threshold detector
`timescale 1ns/100ps
module ptm_phase_detect (
  input wire logic clock_i,
  input wire logic rst_i,
  ptm_det_if.det   det
);
  // Magnitude of a signed sample; the most negative code still fits
  function automatic logic [23:0] mag24(input logic [23:0] s);
    mag24 = s[23] ? 24'(~s + 24'h000001) : s;
  endfunction

  // Zero limit fires always, full-scale limit never fires
  function automatic logic exceeds(input logic [23:0] m,
                                   input logic [23:0] lim);
    if (lim == 24'h000000)
      exceeds = 1'b1;
    else if (lim >= ptm_pkg::FULL_SCALE)
      exceeds = 1'b0;
    else
      exceeds = m > lim;
  endfunction

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      det.hit       <= 3'h0;
      det.hit_valid <= 1'b0;
    end
    else
    begin
      det.hit_valid <= det.strobe;
      if (det.strobe)
      begin
        for (int i = 0; i < 3; i++)
          det.hit[i] <= exceeds(mag24(det.sample[i]), det.limit);
      end
    end
  end
endmodule

// ===== dv/ptm_top_asserts.sv
// Checker of the monitor's register port and interrupt line
`timescale 1ns/100ps
module ptm_top_asserts #(
  parameter int unsigned SAMPLE_CYCLES = ptm_pkg::SAMPLE_CYCLES
) (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        event_interrupt_line_n_o,
  input wire logic [23:0] neutral_rms_result_o
);
  int unsigned cnt_q;

  // ==========================================================
  // Cycles since reset release, saturating
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      cnt_q <= 0;
    else if (cnt_q < SAMPLE_CYCLES)
      cnt_q <= cnt_q + 1;
  end

  default clocking dc @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Register port
  property p_rd_answer;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_no_rvalid;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_no_rvalid: assert property (p_no_rvalid)
    else $error("stray read answer");
  property p_rdata_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved");
  property p_limit_pad;
    reg_rd_i && reg_addr_i inside {8'h00, 8'h04} |=> reg_rdata_o[31:24] == 0;
  endproperty
  a_limit_pad: assert property (p_limit_pad)
    else $error("limit top byte not zero");
  property p_total_pad;
    reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o[31:28] == 4'h0;
  endproperty
  a_total_pad: assert property (p_total_pad)
    else $error("total top bits not zero");
  property p_thr_sext;
    reg_rd_i && reg_addr_i == 8'h0C |=> reg_rdata_o[31:28] == 4'h0
      && reg_rdata_o[27:24] == {4{reg_rdata_o[23]}};
  endproperty
  a_thr_sext: assert property (p_thr_sext)
    else $error("threshold not sign extended");

  // ==========================================================
  // Interrupt line and sample path
  property p_irq_release;
    $rose(event_interrupt_line_n_o) |-> $past(rst_i) || $past(reg_wr_i)
      && $past(reg_addr_i) inside {8'h10, 8'h18};
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt released without a write");
  property p_irq_quiet;
    cnt_q < SAMPLE_CYCLES |-> event_interrupt_line_n_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt before first sample");
  property p_rms_quiet;
    cnt_q < SAMPLE_CYCLES |-> neutral_rms_result_o == 24'h000000;
  endproperty
  a_rms_quiet: assert property (p_rms_quiet)
    else $error("rms result before first sample");
endmodule

bind ptm_top ptm_top_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .event_interrupt_line_n_o, .neutral_rms_result_o
);

// ===== dv/ptm_host.sv
// Host model that reads and clears the monitor over its register port
`timescale 1ns/100ps
module ptm_host (
  input  wire logic        clock_i,
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i,
  output logic [7:0]       reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [31:0]      reg_wdata_o,
  output logic             hung_o
);
  initial
  begin
    reg_addr_o  = 8'hFF;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 32'h0;
    hung_o      = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clock_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit got = 1'b0;
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clock_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    d = 'x;
    for (int i = 0; i < 4 && !got; i++)
    begin
      @(posedge clock_i);
      if (reg_rvalid_i === 1'b1)
      begin
        d   = reg_rdata_i;
        got = 1'b1;
      end
    end
    if (!got)
      hung_o = 1'b1;
  endtask

  // Status first, then phase status, then clear the flags seen
  task automatic service(output logic [31:0] st, output logic [31:0] ph);
    rd(8'h10, st);
    rd(8'h14, ph);
    wr(8'h10, st & 32'h00160000);
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench of the phase threshold event monitor
`timescale 1ns/100ps
module testbench;
  localparam int unsigned SC = 8;
  localparam int FS = ptm_pkg::FULL_SCALE;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [23:0] volt_a_sample_i = 0, volt_b_sample_i = 0, volt_c_sample_i = 0;
  logic [23:0] phase_a_current_sample_i = 0, phase_b_current_sample_i = 0;
  logic [23:0] phase_c_current_sample_i = 0, neutral_current_sample_i = 0;
  logic [23:0] total_rms_i = 24'h3C5A17, neutral_meas_rms_i = 24'h00A5C3;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i, reg_rd_i, reg_rvalid_o, hung;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        event_interrupt_line_n_o;
  logic [23:0] neutral_rms_result_o;
  int          bad_count = 0;
  int          checked = 0;

  always #12.5 clock_i = ~clock_i;

  ptm_top #(.SAMPLE_CYCLES(SC)) dut (
    .clock_i, .rst_i, .volt_a_sample_i, .volt_b_sample_i, .volt_c_sample_i,
    .phase_a_current_sample_i, .phase_b_current_sample_i,
    .phase_c_current_sample_i, .neutral_current_sample_i, .total_rms_i,
    .neutral_meas_rms_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .event_interrupt_line_n_o,
    .neutral_rms_result_o
  );

  ptm_host host (
    .clock_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i), .hung_o(hung)
  );

  // ==========================================================
  // Checking helpers
  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic get(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    cmp(d, e);
  endtask

  always @(posedge clock_i)
  begin
    if (hung)
    begin
      bad_count++;
      results();
    end
  end

  function automatic int mag(input logic [23:0] x);
    int v;
    v = $signed(x);
    return v < 0 ? -v : v;
  endfunction

  function automatic logic [23:0] rnd();
    int r;
    r = $urandom_range(2 * FS) - FS;
    return 24'(r);
  endfunction

  function automatic bit hit(input int m, input int lim);
    return lim == 0 || (lim < FS && m > lim);
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [23:0] vv[3], cc[3], nn, tr, nm;
    logic [31:0] d, st, ph, mk, ew, ep;
    int          lv, li, th, sm, df;
    bit          sel;
    void'($urandom(32'hd99a));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    get(8'h00, {8'h00, ptm_pkg::LIMIT_RST});
    get(8'h04, {8'h00, ptm_pkg::LIMIT_RST});
    get(8'h0C, 32'h0);
    get(8'h40, 32'h0);
    repeat (3 * SC) @(posedge clock_i);
    host.rd(8'h10, d);
    cmp(d & 32'h00100000, 32'h00100000);
    cmp({31'h0, event_interrupt_line_n_o}, 32'h1);
    $display("reset test done");
    for (int it = 0; it < 8; it++)
    begin
      foreach (vv[p])
      begin
        vv[p] = rnd();
        cc[p] = rnd();
      end
      nn = rnd();
      tr = rnd();
      nm = rnd();
      lv = it == 0 ? 0 : it == 1 ? FS
         : it == 2 ? mag(vv[1]) : $urandom_range(FS);
      li = it == 0 ? 0 : it == 1 ? FS
         : it == 2 ? mag(cc[2]) : $urandom_range(FS);
      th = it == 3 ? 0 : it == 4 ? -5 : $urandom_range(FS);
      mk = $urandom & 32'h00160000;
      sel = $urandom_range(1);
      volt_a_sample_i <= vv[0];
      volt_b_sample_i <= vv[1];
      volt_c_sample_i <= vv[2];
      phase_a_current_sample_i <= cc[0];
      phase_b_current_sample_i <= cc[1];
      phase_c_current_sample_i <= cc[2];
      neutral_current_sample_i <= nn;
      total_rms_i <= tr;
      neutral_meas_rms_i <= nm;
      host.wr(8'h00, {8'hA5, 24'(lv)});
      host.wr(8'h04, {8'h5A, 24'(li)});
      host.wr(8'h0C, {8'hFF, 24'(th)});
      host.wr(8'h18, mk);
      host.wr(8'h20, {31'h0, sel});
      host.wr(8'h08, 32'hFFFFFFFF);
      repeat (3 * SC) @(posedge clock_i);
      host.service(st, ph);
      repeat (3 * SC) @(posedge clock_i);
      ew = 0;
      ep = 0;
      foreach (vv[p])
      begin
        ep[9 + p] = hit(mag(vv[p]), lv);
        ep[3 + p] = hit(mag(cc[p]), li);
      end
      ew[18] = |ep[11:9];
      ew[17] = |ep[5:3];
      sm = $signed(cc[0]) + $signed(cc[1]) + $signed(cc[2]);
      df = (sm < 0 ? -sm : sm) - mag(nn);
      df = df < 0 ? -df : df;
      ew[20] = th <= 0 || df > th;
      cmp(32'(event_interrupt_line_n_o), 32'(!(ew & mk)));
      host.service(st, ph);
      cmp(st, ew);
      cmp(ph, ep);
      get(8'h08, {4'h0, 28'(sm)});
      host.rd(8'h1C, d);
      cmp(d & 32'h00020000, 32'h00020000);
      get(8'h00, {8'h00, 24'(lv)});
      get(8'h04, {8'h00, 24'(li)});
      get(8'h0C, {4'h0, {4{th < 0}}, 24'(th)});
      get(8'h18, mk);
      get(8'h20, {31'h0, sel});
      get(8'h24, {8'h00, sel ? tr : nm});
      cmp({8'h0, neutral_rms_result_o}, {8'h0, sel ? tr : nm});
      $display("test %0d done", it);
    end
    volt_a_sample_i <= 0;
    volt_b_sample_i <= 0;
    volt_c_sample_i <= 0;
    phase_a_current_sample_i <= 0;
    phase_b_current_sample_i <= 0;
    phase_c_current_sample_i <= 0;
    neutral_current_sample_i <= 0;
    host.wr(8'h00, FS);
    host.wr(8'h04, FS);
    host.wr(8'h0C, FS);
    host.wr(8'h18, 32'h00160000);
    repeat (3 * SC) @(posedge clock_i);
    host.service(st, ph);
    repeat (3 * SC) @(posedge clock_i);
    cmp({31'h0, event_interrupt_line_n_o}, 32'h1);
    host.service(st, ph);
    cmp(st, 32'h0);
    cmp(ph, 32'h0);
    $display("quiet test done");
    results();
  end
endmodule
